// file: hw/rdsso_clk_div.sv
// Divider giving a one-cycle tick every HALF core cycles while running.
// Assumes run_i is a level from the same clock domain.
module rdsso_clk_div
  import rdsso_pkg::*;
#(
  parameter int HALF = OUT_HALF_CYCLES
) (
  input wire logic clk_i, // Core clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic run_i, // Divider runs while high.
  output logic tick_o     // One-cycle tick.
);

  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(HALF - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [CW-1:0] cnt_reg, cnt_next; // Cycle counter.
  logic tick_reg, tick_next;        // Registered tick.

  // Counts while running and restarts from zero when stopped.
  always_comb begin
    cnt_next = '0;
    tick_next = 1'b0;
    if (run_i) begin
      if (cnt_reg == CNT_LAST) begin
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CNT_ONE;
      end
    end
  end

  // Registers the counter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule : rdsso_clk_div

// file: hw/rdsso_pkg.sv
// Package for the RDS block serial output stage: map, fields, constants.
// Assumes a 100 MHz core clock and a classic Wishbone register slave.
package rdsso_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam int ADR_W = 5;
  localparam logic [ADR_W-1:0] ADR_CTRL = 5'h00;
  localparam logic [ADR_W-1:0] ADR_STATUS = 5'h04;
  localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 5'h08;
  localparam logic [ADR_W-1:0] ADR_IRQ_EN = 5'h0c;
  localparam logic [ADR_W-1:0] ADR_IRQ_CLR = 5'h10;

  // Control register layout and reset value (setting 0, output enabled).
  localparam int CTRL_W = 3;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_SECOND_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h4;

  // Status register layout.
  localparam int STAT_W = 3;
  localparam int STAT_SEL_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // Interrupt status, enable and clear layout.
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_UNCORR_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  localparam int IRQ_SEL_BIT = 3;

  // Serial frame format.
  localparam int FRAME_LEN = 24;
  localparam int FRAME_CNT_W = 5;
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = 5'h17;
  localparam logic START_BIT_VAL = 1'b0;
  localparam logic [1:0] OFFSET_EXT_VAL = 2'b00;
  localparam logic [1:0] SECOND_BLOCK = 2'b01;
  localparam logic [FRAME_LEN-1:0] LINE_IDLE = 24'hffffff;

  // Correction, filtering and reset figures.
  localparam int BURST_W = 5;
  localparam logic [BURST_W-1:0] BURST_MAX = 5'h05;
  localparam logic [BURST_W-1:0] BURST_NONE = 5'h00;
  localparam int SEL_MATCH = 4;
  localparam int RST_HOLD = 4;
  localparam int RST_CNT_W = 3;

  // Output bit clock: half period in core cycles.
  localparam int OUT_HALF_CYCLES = 16;

  // Serializer states.
  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_SHIFT = 1'b1
  } rdsso_ser_e;

  // One received block from the synchroniser.
  typedef struct packed {
    logic [15:0] data;      // Raw information bits.
    logic [15:0] corr_data; // Information bits with the burst repaired.
    logic err;              // Syndrome nonzero.
    logic [BURST_W-1:0] burst_len; // Span of the error burst.
    logic version_b;        // Group version, high for B.
    logic [1:0] block_number; // Block position in the group.
  } rdsso_blk_s;

  // Integrity decision for one block.
  typedef struct packed {
    logic error_f;
    logic corr_f;
    logic use_corr;
  } rdsso_integ_s;

endpackage : rdsso_pkg

// file: hw/rdsso_sel_filter.sv
// Sample filter for the correction-select level.
// Assumes the input is already synchronised and sample_en is a pulse.
module rdsso_sel_filter
  import rdsso_pkg::*;
#(
  parameter int MATCH = SEL_MATCH
) (
  input wire logic clk_i,      // Core clock.
  input wire logic rst_i,      // Synchronous reset, active high.
  input wire logic sample_en_i, // Take one sample now.
  input wire logic level_i,    // Synchronised select level.
  output logic filtered_o,     // Adopted select value.
  output logic changed_o       // Pulse when a new value is adopted.
);

  localparam int CW = $clog2(MATCH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(MATCH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic cand_reg, cand_next;       // Value of the current sample run.
  logic [CW-1:0] cnt_reg, cnt_next; // Length of that run.
  logic filt_reg, filt_next;       // Adopted value.
  logic chg_reg, chg_next;         // Adoption pulse.

  // Counts runs of equal samples and adopts a value after a full run.
  always_comb begin
    cand_next = cand_reg;
    cnt_next = cnt_reg;
    filt_next = filt_reg;
    chg_next = 1'b0;
    if (sample_en_i) begin
      if (level_i == cand_reg) begin
        if (cnt_reg != CNT_FULL) begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end else begin
        cand_next = level_i;
        cnt_next = CNT_ONE;
      end
      if (cnt_next == CNT_FULL && cand_next != filt_reg) begin
        filt_next = cand_next;
        chg_next = 1'b1;
      end
    end
  end

  // Registers the filter state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cand_reg <= 1'b0;
      cnt_reg <= '0;
      filt_reg <= 1'b0;
      chg_reg <= 1'b0;
    end else begin
      cand_reg <= cand_next;
      cnt_reg <= cnt_next;
      filt_reg <= filt_next;
      chg_reg <= chg_next;
    end
  end

  assign filtered_o = filt_reg;
  assign changed_o = chg_reg;

endmodule : rdsso_sel_filter

// file: hw/rdsso_top.sv
// Top of the RDS block serial output stage with its Wishbone registers.
// Assumes blocks arrive as single-cycle valid pulses from synchroniser
// logic on CLK_I; pins RESET_N_I, CORRECTION_SELECT_I and DEMOD_CLK_I are async.
//
// What this block does
// - Frame opens with a low start bit.
// - Error/correction flags encode block integrity.
// - Two offset extension bits sent low.
// - Version bit: low A, high B.
// - Two-bit block number, blocks one to four.
// - Sixteen data bits, fifteen down to zero.
// - Drive output clock with data and strobe.
// - Hunting: sample select per bit, four matches.
// - Synced: sample select per block, four matches.
// - Select may change anytime, no reset needed.
// - Select low passes, high corrects blocks.
// - Correct bursts up to five bits only.
// - Four settings: clock edge, strobe per block.
// - Reset pin low four cycles restarts.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
module rdsso_top
  import rdsso_pkg::*;
#(
  parameter int HALF_BIT = OUT_HALF_CYCLES
) (
  input wire logic CLK_I,               // Core clock, 100 MHz.
  input wire logic RST_I,               // Synchronous reset, active high.
  input wire logic [ADR_W-1:0] ADR_I,   // Wishbone byte address.
  input wire logic [31:0] DAT_I,        // Wishbone write data.
  output logic [31:0] DAT_O,            // Wishbone read data.
  input wire logic WE_I,                // Wishbone write enable.
  input wire logic [3:0] SEL_I,         // Wishbone byte selects.
  input wire logic STB_I,               // Wishbone strobe.
  input wire logic CYC_I,               // Wishbone cycle.
  output logic ACK_O,                   // Wishbone acknowledge.
  output logic IRQ_O,                   // Level interrupt.
  input wire logic RESET_N_I,           // Reset pin, active low.
  input wire logic CORRECTION_SELECT_I,          // Correction select pin.
  input wire logic DEMOD_CLK_I,         // Demodulated bit clock pin.
  input wire logic SYNC_I,              // Block sync achieved.
  input wire logic BLK_VALID_I,         // Block start pulse.
  input wire rdsso_blk_s BLK_I,         // Received block.
  output logic DATA_O,                  // Serial data out.
  output logic CLK_OUT_O,               // Serial clock out.
  output logic DATA_START_O             // Block start strobe.
);

  // Integrity decision for a block, given the filtered select.
  function automatic rdsso_integ_s integ(input rdsso_blk_s b,
                                         input logic corr_en);
    rdsso_integ_s r;
    r = '0;
    if (!b.err) begin
      r = '0;
    end else if (corr_en && b.burst_len != BURST_NONE &&
                 b.burst_len <= BURST_MAX) begin
      r.corr_f = 1'b1;
      r.use_corr = 1'b1;
    end else begin
      r.error_f = 1'b1;
      r.corr_f = 1'b1;
    end
    return r;
  endfunction : integ

  // Pin synchronisers; the first stage feeds only the second.
  logic rstn_s1, rstn_s2;   // Reset pin stages.
  logic sel_s1, sel_s2;     // Select pin stages.
  logic dclk_s1, dclk_s2;   // Bit clock stages.
  logic dclk_d;             // Delayed bit clock for edge finding.

  // Registers every pin through two flip-flops.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rstn_s1 <= 1'b1;
      rstn_s2 <= 1'b1;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      dclk_s1 <= 1'b0;
      dclk_s2 <= 1'b0;
      dclk_d <= 1'b0;
    end else begin
      rstn_s1 <= RESET_N_I;
      rstn_s2 <= rstn_s1;
      sel_s1 <= CORRECTION_SELECT_I;
      sel_s2 <= sel_s1;
      dclk_s1 <= DEMOD_CLK_I;
      dclk_s2 <= dclk_s1;
      dclk_d <= dclk_s2;
    end
  end

  // Reset pin hold counter.
  localparam logic [RST_CNT_W-1:0] RST_FULL = RST_CNT_W'(RST_HOLD);
  localparam logic [RST_CNT_W-1:0] RST_ONE = RST_CNT_W'(1);
  logic [RST_CNT_W-1:0] rcnt_reg, rcnt_next; // Low cycles seen.
  logic soft_rst;                            // Internal reset.

  always_comb begin
    rcnt_next = '0;
    if (!rstn_s2) begin
      rcnt_next = (rcnt_reg == RST_FULL) ? rcnt_reg : rcnt_reg + RST_ONE;
    end
  end

  // Registers the hold counter; the bus reset clears it, not soft_rst.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rcnt_reg <= '0;
    end else begin
      rcnt_reg <= rcnt_next;
    end
  end

  assign soft_rst = RST_I || (rcnt_reg == RST_FULL);

  // Correction-select filter.
  logic bit_tick;   // Rising edge of the demodulated bit clock.
  logic sel_sample; // Sample moment for the filter.
  logic corr_en;    // Filtered select.
  logic sel_changed; // Adoption pulse.

  assign bit_tick = dclk_s2 && !dclk_d;
  assign sel_sample = SYNC_I ? BLK_VALID_I : bit_tick;

  rdsso_sel_filter #(
    .MATCH(SEL_MATCH)
  ) u_filter (
    .clk_i(CLK_I),
    .rst_i(soft_rst),
    .sample_en_i(sel_sample),
    .level_i(sel_s2),
    .filtered_o(corr_en),
    .changed_o(sel_changed)
  );

  // Serializer state.
  rdsso_ser_e st_reg, st_next;                // Serializer state.
  logic [FRAME_LEN-1:0] sh_reg, sh_next;      // Frame shift register.
  logic [FRAME_CNT_W-1:0] bc_reg, bc_next;    // Bit index.
  logic ph_reg, ph_next;                      // High in second half-bit.
  logic ds_reg, ds_next;                      // Start strobe.
  logic half_tick;                            // Half-bit enable.
  logic load;                                 // Frame taken.
  logic overrun;                              // Block lost while busy.
  logic uncorr;                               // Uncorrectable block.
  logic frame_done;                           // Last bit ended.
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;     // Control register.
  rdsso_integ_s in_integ;                     // Decision for BLK_I.
  logic [15:0] out_data;                      // Data bits to send.

  assign in_integ = integ(BLK_I, corr_en);
  assign out_data = in_integ.use_corr ? BLK_I.corr_data : BLK_I.data;
  assign load = BLK_VALID_I && (st_reg == SER_IDLE) && ctrl_reg[CTRL_EN_BIT];
  assign overrun = BLK_VALID_I && (st_reg == SER_SHIFT);
  assign uncorr = load && in_integ.error_f;
  assign frame_done = half_tick && ph_reg && (bc_reg == FRAME_LAST);

  rdsso_clk_div #(
    .HALF(HALF_BIT)
  ) u_div (
    .clk_i(CLK_I),
    .rst_i(soft_rst),
    .run_i(st_reg == SER_SHIFT),
    .tick_o(half_tick)
  );

  // Loads a frame, then shifts one bit per two half-bit ticks.
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    bc_next = bc_reg;
    ph_next = ph_reg;
    ds_next = ds_reg;
    case (st_reg)
      SER_IDLE: begin
        if (load) begin
          sh_next = {START_BIT_VAL, in_integ.error_f, in_integ.corr_f,
                     OFFSET_EXT_VAL, BLK_I.version_b, BLK_I.block_number,
                     out_data};
          bc_next = '0;
          ph_next = 1'b0;
          st_next = SER_SHIFT;
          ds_next = !ctrl_reg[CTRL_SECOND_BIT] ||
                    (BLK_I.block_number == SECOND_BLOCK);
        end
      end
      SER_SHIFT: begin
        if (half_tick) begin
          if (!ph_reg) begin
            // Active edge falls in the middle of the bit.
            ph_next = 1'b1;
          end else begin
            ph_next = 1'b0;
            ds_next = 1'b0;
            sh_next = {sh_reg[FRAME_LEN-2:0], 1'b1};
            bc_next = bc_reg + 5'h01;
            if (bc_reg == FRAME_LAST) begin
              st_next = SER_IDLE;
              sh_next = LINE_IDLE;
              bc_next = '0;
            end
          end
        end
      end
      default: begin
        st_next = SER_IDLE;
      end
    endcase
  end

  // Registers the serializer.
  always_ff @(posedge CLK_I) begin
    if (soft_rst) begin
      st_reg <= SER_IDLE;
      sh_reg <= LINE_IDLE;
      bc_reg <= '0;
      ph_reg <= 1'b0;
      ds_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      bc_reg <= bc_next;
      ph_reg <= ph_next;
      ds_reg <= ds_next;
    end
  end

  assign DATA_O = sh_reg[FRAME_LEN-1];
  assign CLK_OUT_O = ctrl_reg[CTRL_POL_BIT] ? ph_reg : !ph_reg;
  assign DATA_START_O = ds_reg;

  // Wishbone slave and interrupt registers.
  logic ack_reg, ack_next;              // Acknowledge.
  logic [31:0] dat_reg, dat_next;       // Read data.
  logic [IRQ_W-1:0] ist_reg, ist_next;  // Sticky event bits.
  logic [IRQ_W-1:0] ien_reg, ien_next;  // Interrupt enables.
  logic [IRQ_W-1:0] events;             // Events this cycle.
  logic [IRQ_W-1:0] clr;                // Clear bits written.
  logic req;                            // Request pending.
  logic wr;                             // Write taking effect.
  logic [STAT_W-1:0] status;            // Live status.

  assign req = CYC_I && STB_I;
  assign wr = req && ack_reg && WE_I && SEL_I[0];
  assign events = {sel_changed, overrun, uncorr, frame_done};
  assign status = {st_reg == SER_SHIFT, SYNC_I, corr_en};

  // Decodes the bus, updates control and event bits.
  always_comb begin
    ack_next = req && !ack_reg;
    dat_next = dat_reg;
    ctrl_next = ctrl_reg;
    ien_next = ien_reg;
    clr = '0;
    if (req && !ack_reg) begin
      if (ADR_I == ADR_CTRL) begin
        dat_next = {29'h0, ctrl_reg};
      end else if (ADR_I == ADR_STATUS) begin
        dat_next = {29'h0, status};
      end else if (ADR_I == ADR_IRQ_STAT) begin
        dat_next = {28'h0, ist_reg};
      end else if (ADR_I == ADR_IRQ_EN) begin
        dat_next = {28'h0, ien_reg};
      end else begin
        dat_next = 32'h0;
      end
    end
    if (wr) begin
      if (ADR_I == ADR_CTRL) begin
        ctrl_next = DAT_I[CTRL_W-1:0];
      end else if (ADR_I == ADR_IRQ_EN) begin
        ien_next = DAT_I[IRQ_W-1:0];
      end else if (ADR_I == ADR_IRQ_CLR) begin
        clr = DAT_I[IRQ_W-1:0];
      end
    end
    // A new event wins over a clear in the same cycle.
    ist_next = (ist_reg & ~clr) | events;
  end

  // Registers the bus side.
  always_ff @(posedge CLK_I) begin
    if (soft_rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      ctrl_reg <= CTRL_RESET;
      ist_reg <= '0;
      ien_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      ctrl_reg <= ctrl_next;
      ist_reg <= ist_next;
      ien_reg <= ien_next;
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;
  assign IRQ_O = |(ist_reg & ien_reg);

endmodule : rdsso_top

// file: test/rdsso_host_model.sv
// Host model that receives serial frames from the output stage.
// Assumes pol_i is high when the rising clock edge is the active one.
module rdsso_host_model (
  input wire logic clk_i,      // Core clock, samples the link pins.
  input wire logic rst_i,      // Synchronous reset, active high.
  input wire logic pol_i,      // Active clock level.
  input wire logic data_i,     // Serial data pin.
  input wire logic clk_out_i,  // Serial clock pin.
  input wire logic start_i,    // Block start strobe pin.
  output logic [23:0] frame_o, // Last whole frame, first bit highest.
  output logic done_o,         // One-cycle pulse per whole frame.
  output logic strobe_o        // Strobe seen with the last frame.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ck_reg;        // Clock pin one cycle ago.
  logic [4:0] n_reg;   // Bits taken of this frame.
  logic [23:0] sh_reg; // Bits taken so far.
  logic st_reg;        // Strobe seen on the first bit.
  logic act;           // Active clock edge seen this cycle.

  assign act = (clk_out_i != ck_reg) && (clk_out_i == pol_i);

  // Shifts one bit per active edge and hands on whole frames.
  always_ff @(posedge clk_i) begin
    ck_reg <= clk_out_i;
    done_o <= 1'b0;
    if (rst_i) begin
      n_reg <= 5'h00;
    end else if (act) begin
      if (start_i || n_reg == 5'h00) begin
        sh_reg <= {23'h0, data_i};
        st_reg <= start_i;
        n_reg <= 5'h01;
      end else if (n_reg == 5'h17) begin
        frame_o <= {sh_reg[22:0], data_i};
        strobe_o <= st_reg;
        done_o <= 1'b1;
        n_reg <= 5'h00;
      end else begin
        sh_reg <= {sh_reg[22:0], data_i};
        n_reg <= n_reg + 5'h01;
      end
    end
  end
endmodule : rdsso_host_model

// file: test/rdsso_monitor.sv
// Checker for the RDS serial output stage, seen at its top ports.
// Assumes one clock domain, CLK_I, with RST_I as its reset.
module rdsso_monitor
  import rdsso_pkg::*;
#(
  parameter int HALF_BIT = OUT_HALF_CYCLES
) (
  input wire logic CLK_I,             // Core clock.
  input wire logic RST_I,             // Synchronous reset.
  input wire logic [ADR_W-1:0] ADR_I, // Bus address.
  input wire logic WE_I,              // Bus write enable.
  input wire logic STB_I,             // Bus strobe.
  input wire logic CYC_I,             // Bus cycle.
  input wire logic ACK_O,             // Bus acknowledge.
  input wire logic [31:0] DAT_O,      // Bus read data.
  input wire logic IRQ_O,             // Interrupt level.
  input wire logic RESET_N_I,         // Reset pin, active low.
  input wire logic DATA_O,            // Serial data.
  input wire logic CLK_OUT_O,         // Serial clock.
  input wire logic DATA_START_O       // Block start strobe.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] st_cnt_reg, st_cnt_next; // Cycles the strobe stood high.
  logic [3:0] rn_cnt_reg, rn_cnt_next; // Cycles the reset pin was low.

  // Next counts; both saturate and restart when the strobe drops or the pin rises.
  always_comb begin
    st_cnt_next = 8'h00;
    rn_cnt_next = 4'h0;
    if (DATA_START_O) begin
      st_cnt_next = st_cnt_reg + {7'h0, st_cnt_reg != 8'hff};
    end
    if (!RESET_N_I) begin
      rn_cnt_next = rn_cnt_reg + {3'h0, rn_cnt_reg != 4'hf};
    end
  end

  // Registers the counts.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_cnt_reg <= 8'h00;
      rn_cnt_reg <= 4'h0;
    end else begin
      st_cnt_reg <= st_cnt_next;
      rn_cnt_reg <= rn_cnt_next;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_take; CYC_I && STB_I && !ACK_O; endsequence
  sequence s_answer; ACK_O ##1 !ACK_O; endsequence

  a_ack_timing: assert property (s_take |=> s_answer)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I) && $past(STB_I))
    else $error("ack without request");
  a_rsv_zero: assert property (ACK_O && !$past(WE_I) &&
    $past(ADR_I) >= ADR_IRQ_CLR |-> DAT_O == 32'h0)
    else $error("clear or unmapped read not zero");
  a_data_upper: assert property (ACK_O |-> DAT_O[31:4] == 28'h0)
    else $error("upper read bits not zero");
  a_start_low: assert property (DATA_START_O |-> !DATA_O)
    else $error("start bit not low under strobe");
  // The registered divider tick stretches the start bit by one cycle.
  a_bit_len: assert property ($fell(DATA_START_O) |->
    st_cnt_reg == 8'(2 * HALF_BIT + 1))
    else $error("start bit length wrong");
  a_clk_still: assert property ($rose(DATA_START_O) |->
    $stable(CLK_OUT_O))
    else $error("clock moved at frame start");
  a_pin_idle: assert property (rn_cnt_reg >= 4'ha |-> DATA_O &&
    !DATA_START_O && CLK_OUT_O && !IRQ_O && !ACK_O)
    else $error("outputs not idle in pin reset");
endmodule : rdsso_monitor

bind rdsso_top rdsso_monitor #(.HALF_BIT(HALF_BIT)) mon_u (
  .CLK_I(CLK_I), .RST_I(RST_I), .ADR_I(ADR_I), .WE_I(WE_I),
  .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
  .IRQ_O(IRQ_O), .RESET_N_I(RESET_N_I), .DATA_O(DATA_O),
  .CLK_OUT_O(CLK_OUT_O), .DATA_START_O(DATA_START_O));

// file: test/tb_top.sv
// Self-checking bench for the RDS block serial output stage.
// Assumes the hw/ package and top plus the host model and checker.
module tb_top;
  import rdsso_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HB = 2; // Short half bit keeps frames quick.
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] dat_w = 32'h0, dat_r, rd;
  logic [3:0] sel = 4'h0;
  logic ack, irq, sdo, sck, sst, hdone, hstrobe, pol = 1'b0;
  logic rst_n = 1'b1, csel = 1'b0, dclk = 1'b0, sync = 1'b0, bv = 1'b0;
  logic drun = 1'b0, ctog = 1'b0;
  logic [23:0] hframe, fr;
  rdsso_blk_s blk = '0;
  int err_total = 0, checks = 0;

  always #5 clk = ~clk;
  // Bit clock at 125 ns, offset so its edges never meet core edges.
  initial begin
    #3;
    forever #62.5 if (drun) dclk = ~dclk;
  end
  // Flips the select pin between bit samples when asked.
  always @(negedge dclk) if (ctog) csel = ~csel;

  rdsso_top #(.HALF_BIT(HB)) dut_u (.CLK_I(clk), .RST_I(rst),
    .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r), .WE_I(we), .SEL_I(sel),
    .STB_I(stb), .CYC_I(cyc), .ACK_O(ack), .IRQ_O(irq),
    .RESET_N_I(rst_n), .CORRECTION_SELECT_I(csel), .DEMOD_CLK_I(dclk),
    .SYNC_I(sync), .BLK_VALID_I(bv), .BLK_I(blk), .DATA_O(sdo),
    .CLK_OUT_O(sck), .DATA_START_O(sst));
  rdsso_host_model host_u (.clk_i(clk), .rst_i(rst), .pol_i(pol),
    .data_i(sdo), .clk_out_i(sck), .start_i(sst), .frame_o(hframe),
    .done_o(hdone), .strobe_o(hstrobe));

  // Counts a compare and reports a mismatch.
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // One classic bus cycle, held until ack is sampled.
  task automatic wb(logic w, logic [ADR_W-1:0] a, logic [31:0] d,
                    logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_r;
    {cyc, stb, we} <= 3'b000;
  endtask : wb

  task automatic rdc(string n, logic [ADR_W-1:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    check(n, rd, e);
  endtask : rdc

  function automatic rdsso_blk_s mkb(logic [15:0] d, logic e,
    logic [4:0] bl, logic v, logic [1:0] n);
    return '{data: d, corr_data: ~d, err: e, burst_len: bl,
             version_b: v, block_number: n};
  endfunction : mkb

  // Expected frame from the block and the adopted select value.
  function automatic logic [23:0] expf(rdsso_blk_s b, logic c);
    logic ok;
    ok = c && b.err && b.burst_len >= 5'h01 && b.burst_len <= BURST_MAX;
    return {START_BIT_VAL, b.err && !ok, b.err, OFFSET_EXT_VAL,
            b.version_b, b.block_number, ok ? b.corr_data : b.data};
  endfunction : expf

  // Hands in one block and waits for the host to take the frame.
  task automatic send(rdsso_blk_s b);
    @(posedge clk);
    {bv, blk} <= {1'b1, b};
    @(posedge clk);
    bv <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      if (hdone === 1'b1) break;
    end
    fr = (hdone === 1'b1) ? hframe : 24'hx;
    repeat (2 * HB + 4) @(posedge clk);
  endtask : send

  task automatic frame(string n, rdsso_blk_s b, logic c, logic s2);
    send(b);
    check(n, {8'h0, fr}, {8'h0, expf(b, c)});
    check({n, " strobe"}, {31'h0, hstrobe},
          {31'h0, !s2 || b.block_number == SECOND_BLOCK});
  endtask : frame

  task automatic t_regs();
    rdc("ctrl", ADR_CTRL, 32'(CTRL_RESET));
    rdc("status", ADR_STATUS, 32'h0);
    rdc("irq status", ADR_IRQ_STAT, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h3, 4'h0);
    rdc("ctrl no lane", ADR_CTRL, 32'(CTRL_RESET));
    wb(1'b1, 5'h14, 32'hf, 4'hf);
    rdc("unmapped", 5'h14, 32'h0);
    rdc("clear reg", ADR_IRQ_CLR, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_frames();
    for (int i = 0; i < 4; i++) begin
      frame("frame", mkb(16'hb2c5 + 16'(i), 1'b0, 5'h0, i[0], 2'(i)),
            1'b0, 1'b0);
    end
    $display("t_frames done");
  endtask : t_frames

  task automatic t_corr();
    logic [4:0] bl[5] = '{5'h1, 5'h5, 5'h6, 5'h0, 5'h3};
    frame("raw", mkb(16'h1234, 1'b1, 5'h2, 1'b0, 2'h0), 1'b0,
          1'b0);
    {ctog, drun} = 2'b11;
    repeat (100) @(posedge clk);
    ctog = 1'b0;
    rdc("flicker", ADR_STATUS, 32'h0);
    csel <= 1'b1;
    repeat (125) @(posedge clk);
    rdc("adopted", ADR_STATUS, 32'h1);
    foreach (bl[k]) begin
      frame("corr", mkb(16'h5a0f, k < 4, bl[k], 1'b1, 2'h2), 1'b1,
            1'b0);
    end
    rdc("events", ADR_IRQ_STAT, 32'hb);
    $display("t_corr done");
  endtask : t_corr

  task automatic t_synced();
    {sync, csel} <= 2'b10;
    for (int k = 0; k < 5; k++) begin
      rdc("synced", ADR_STATUS, k < 4 ? 32'h3 : 32'h2);
      if (k < 4) send(mkb(16'h0, 1'b0, 5'h0, 1'b0, 2'(k)));
    end
    sync <= 1'b0;
    drun = 1'b0;
    $display("t_synced done");
  endtask : t_synced

  task automatic t_settings();
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, ADR_CTRL, 32'h4 | 32'(s), 4'hf);
      pol <= s[0];
      repeat (2) @(posedge clk);
      check("idle clock", {31'h0, sck}, {31'h0, ~pol});
      for (int n = 0; n < 4; n++) begin
        frame("setting", mkb(16'h0ff0 ^ 16'(n), 1'b0, 5'h0, 1'b1, 2'(n)),
              1'b0, s[1]);
      end
    end
    wb(1'b1, ADR_CTRL, 32'(CTRL_RESET), 4'hf);
    pol <= 1'b0;
    $display("t_settings done");
  endtask : t_settings

  task automatic t_irq();
    wb(1'b1, ADR_IRQ_CLR, 32'hf, 4'hf);
    rdc("cleared", ADR_IRQ_STAT, 32'h0);
    wb(1'b1, ADR_IRQ_EN, 32'h1, 4'hf);
    send(mkb(16'h0001, 1'b0, 5'h0, 1'b0, 2'h3));
    check("irq raised", {31'h0, irq}, 32'h1);
    wb(1'b1, ADR_IRQ_EN, 32'h0, 4'hf);
    @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wb(1'b1, ADR_IRQ_EN, 32'hf, 4'hf);
    @(posedge clk);
    bv <= 1'b1;
    repeat (2) @(posedge clk);
    bv <= 1'b0;
    repeat (120) @(posedge clk);
    rdc("overrun", ADR_IRQ_STAT, 32'h5);
    wb(1'b1, ADR_IRQ_CLR, 32'h5, 4'hf);
    @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    $display("t_irq done");
  endtask : t_irq

  task automatic t_pinrst();
    int hold[3] = '{3, 4, 12};
    foreach (hold[k]) begin
      wb(1'b1, ADR_CTRL, 32'h3, 4'hf);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (hold[k]) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      rdc("pin reset", ADR_CTRL, k == 0 ? 32'h3 : 32'h4);
    end
    $display("t_pinrst done");
  endtask : t_pinrst

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_frames();
    t_corr();
    t_synced();
    t_settings();
    t_irq();
    t_pinrst();
    results();
  end

  // Cuts a hang short at well over the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[FAIL] watchdog expected end seen hang");
    results();
  end
endmodule : tb_top
